// ---- hw/addr_match.sv ----
// Destination match against node, group and broadcast addresses
`timescale 1ns/1ns
`include "cfg_defines.svh"
module addr_match (
	input wire logic [7:0] dest,
	input wire logic [7:0] node,
	input wire logic [31:0] group,
	output logic hit
);
	logic [3:0] grp_hit;
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_grp
			// Unused channels hold 0x00 and never match a group frame
			assign grp_hit[g] = (group[8*g +: 8] == dest) &&
				(dest >= `GRP_MIN);
		end
	endgenerate
	assign hit = (dest == node) || (|grp_hit) ||
		(dest == `ADDR_BCAST);
endmodule // addr_match

// ---- hw/cfg_decoder.sv ----
// Factory configuration command decoder with AXI4-Lite register port
`timescale 1ns/1ns
`include "cfg_defines.svh"
module cfg_decoder (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic RX_VALID,
	input wire logic [7:0] RX_DATA,
	output logic RX_READY,
	output logic TX_VALID,
	output logic [7:0] TX_DATA,
	input wire logic TX_READY,
	output cfg_pkg::settings_s SETTINGS,
	output logic IRQ,
	input wire logic [31:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [31:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY
);
	cfg_pkg::rx_state_e state_q;
	cfg_pkg::settings_s set_q;
	cfg_pkg::byte_s tx_byte;
	logic [7:0] frm_q [0:13];
	logic [3:0] idx_q;
	logic [15:0] sum_q;
	logic hit;
	logic tx_busy;
	logic tx_take;
	logic tx_start_q;
	logic [7:0] status_q;
	logic [7:0] last_op_q;
	logic reply_en_q;
	logic factory_q;
	logic [2:0] irq_st_q;
	logic [2:0] irq_en_q;
	logic [2:0] irq_clr;
	logic [2:0] ev;
	logic [7:0] op;
	logic [7:0] p0;
	logic [15:0] p16;
	logic key_ok;
	logic frame_ok;
	logic [15:0] rx_sum;
	logic aw_q;
	logic w_q;
	logic [7:0] awa_q;
	logic [31:0] wd_q;
	logic [7:0] ar;

	assign op = frm_q[2];
	assign p0 = frm_q[7];
	assign p16 = {frm_q[8], frm_q[7]};
	assign rx_sum = {frm_q[13], frm_q[12]};
	assign key_ok = frm_q[3] == `KEY_B0 && frm_q[4] == `KEY_B1 &&
		frm_q[5] == `KEY_B2 && frm_q[6] == `KEY_B3;
	assign frame_ok = frm_q[0] == `FRM_HEADER &&
		frm_q[11] == `FRM_TRAILER && rx_sum == sum_q;
	// Serialiser steps only when the output register is free or taken
	assign tx_take = !TX_VALID || TX_READY;

	addr_match u_match (
		.dest(frm_q[1]),
		.node(set_q.node),
		.group(set_q.group),
		.hit(hit)
	);

	reply_tx u_reply (
		.clk(CLK),
		.rst_n(RST_N),
		.start(tx_start_q),
		.addr(set_q.node),
		.status(status_q),
		.sparam({8'h00, last_op_q}),
		.ready(tx_take),
		.out(tx_byte),
		.busy(tx_busy)
	);

	// Frame capture: 14 bytes, sum over bytes 0 to 11 (header through trailer)
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			state_q <= cfg_pkg::RX_IDLE;
			idx_q <= 4'h0;
			sum_q <= 16'h0000;
			RX_READY <= 1'b0;
		end else begin
			case (state_q)
				cfg_pkg::RX_IDLE: begin
					// Closed while a reply is pending or still leaving
					RX_READY <= !tx_busy && !tx_start_q && !TX_VALID;
					if (RX_VALID && RX_READY &&
						RX_DATA == `FRM_HEADER) begin
						idx_q <= 4'h1;
						// Header is the first byte of the sum
						sum_q <= {8'h00, RX_DATA};
						state_q <= cfg_pkg::RX_BODY;
					end
				end
				cfg_pkg::RX_BODY: begin
					if (RX_VALID && RX_READY) begin
						if (idx_q <= 4'hb)
							sum_q <= sum_q + {8'h00, RX_DATA};
						idx_q <= idx_q + 4'h1;
						if (idx_q == `REQ_LEN) begin
							RX_READY <= 1'b0;
							state_q <= cfg_pkg::RX_EXEC;
						end
					end
				end
				cfg_pkg::RX_EXEC: state_q <= cfg_pkg::RX_IDLE;
				default: state_q <= cfg_pkg::RX_IDLE;
			endcase
		end
	end

	always_ff @(posedge CLK) begin
		if (state_q == cfg_pkg::RX_IDLE && RX_VALID && RX_READY)
			frm_q[0] <= RX_DATA;
		else if (state_q == cfg_pkg::RX_BODY && RX_VALID && RX_READY)
			frm_q[idx_q] <= RX_DATA;
	end

	// Command execution; settings only change on reset, a clean keyed frame or a factory reload from CTRL bit 1
	always_ff @(posedge CLK) begin
		if (!RST_N || factory_q) begin
			set_q.node <= `DEF_NODE;
			set_q.rs232 <= `DEF_UART;
			set_q.rs485 <= `DEF_UART;
			set_q.can <= `DEF_CAN;
			set_q.subdiv <= `DEF_SUB;
			set_q.speed <= `DEF_SPD;
			set_q.home <= `DEF_HOME;
			set_q.can_dst <= `DEF_CANDST;
			set_q.group <= {4{`DEF_GRP}};
			status_q <= `ST_OK;
			last_op_q <= 8'h00;
			tx_start_q <= 1'b0;
			ev <= 3'h0;
		end else begin
			tx_start_q <= 1'b0;
			ev <= 3'h0;
			if (state_q == cfg_pkg::RX_EXEC && hit) begin
				last_op_q <= op;
				tx_start_q <= reply_en_q;
				if (!frame_ok) begin
					status_q <= `ST_FRAME;
					ev[1] <= 1'b1;
				end else if (!key_ok) begin
					status_q <= `ST_REJECT;
					ev[1] <= 1'b1;
				end else begin
					status_q <= `ST_OK;
					ev[0] <= 1'b1;
					case (op)
						`OP_NODE:
							if (p0 <= `NODE_MAX) set_q.node <= p0;
							else status_q <= `ST_PARAM;
						`OP_R232:
							if (p0 <= `UART_MAX) set_q.rs232 <= p0[2:0];
							else status_q <= `ST_PARAM;
						`OP_R485:
							if (p0 <= `UART_MAX) set_q.rs485 <= p0[2:0];
							else status_q <= `ST_PARAM;
						`OP_CAN:
							if (p0 <= `CAN_MAX) set_q.can <= p0[1:0];
							else status_q <= `ST_PARAM;
						`OP_SUBDIV:
							if (p0 >= `SUB_MIN && p0 <= `SUB_MAX)
								set_q.subdiv <= p0[2:0];
							else status_q <= `ST_PARAM;
						`OP_SPEED:
							if (p16 >= `SPD_MIN && p16 <= `SPD_MAX)
								set_q.speed <= p16;
							else status_q <= `ST_PARAM;
						`OP_HOME:
							if (p16 <= 16'h0001) set_q.home <= p16[0];
							else status_q <= `ST_PARAM;
						`OP_CANDST: set_q.can_dst <= p0;
						default:
							if (op >= `OP_GRP0 && op <= `OP_GRP3 &&
								p0 >= `GRP_MIN && p0 <= `GRP_MAX)
								set_q.group[8*op[1:0] +: 8] <= p0;
							else status_q <= `ST_PARAM;
					endcase
					ev[2] <= 1'b0;
				end
			end
			if (state_q == cfg_pkg::RX_EXEC && hit && frame_ok && key_ok &&
				!(op inside {`OP_NODE, `OP_R232, `OP_R485, `OP_CAN,
				`OP_SUBDIV, `OP_SPEED, `OP_HOME, `OP_CANDST}) &&
				!(op >= `OP_GRP0 && op <= `OP_GRP3))
				ev[2] <= 1'b1;
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			irq_st_q <= 3'h0;
			IRQ <= 1'b0;
		end else begin
			irq_st_q <= (irq_st_q & ~irq_clr) | ev;
			IRQ <= |(((irq_st_q & ~irq_clr) | ev) & irq_en_q);
		end
	end

	// AXI4-Lite slave, one write and one read at a time
	assign irq_clr = (aw_q && w_q && !S_AXI_BVALID &&
		awa_q == `AX_IRQ_CLR) ? wd_q[2:0] : 3'h0;
	assign ar = S_AXI_ARADDR[7:0];

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			aw_q <= 1'b0;
			w_q <= 1'b0;
			awa_q <= 8'h00;
			wd_q <= 32'h0;
			S_AXI_AWREADY <= 1'b0;
			S_AXI_WREADY <= 1'b0;
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= 2'h0;
			reply_en_q <= 1'b1;
			factory_q <= 1'b0;
			irq_en_q <= 3'h0;
		end else begin
			factory_q <= 1'b0;
			S_AXI_AWREADY <= !aw_q && !S_AXI_AWREADY && !S_AXI_BVALID;
			S_AXI_WREADY <= !w_q && !S_AXI_WREADY && !S_AXI_BVALID;
			if (S_AXI_AWVALID && S_AXI_AWREADY) begin
				aw_q <= 1'b1;
				awa_q <= S_AXI_AWADDR[7:0];
				S_AXI_AWREADY <= 1'b0;
			end
			if (S_AXI_WVALID && S_AXI_WREADY) begin
				w_q <= 1'b1;
				wd_q <= S_AXI_WDATA;
				S_AXI_WREADY <= 1'b0;
			end
			if (aw_q && w_q && !S_AXI_BVALID) begin
				S_AXI_BVALID <= 1'b1;
				S_AXI_BRESP <= 2'h0;
				case (awa_q)
					{4'h0, `AX_CTRL}: begin
						reply_en_q <= wd_q[0];
						factory_q <= wd_q[1];
					end
					{4'h0, `AX_IRQ_CLR}: ;
					`AX_IRQ_EN: irq_en_q <= wd_q[2:0];
					default: S_AXI_BRESP <= 2'h2;
				endcase
			end
			if (S_AXI_BVALID && S_AXI_BREADY) begin
				S_AXI_BVALID <= 1'b0;
				aw_q <= 1'b0;
				w_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			S_AXI_ARREADY <= 1'b0;
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA <= 32'h0;
			S_AXI_RRESP <= 2'h0;
		end else begin
			S_AXI_ARREADY <= !S_AXI_ARREADY && !S_AXI_RVALID;
			if (S_AXI_ARVALID && S_AXI_ARREADY) begin
				S_AXI_ARREADY <= 1'b0;
				S_AXI_RVALID <= 1'b1;
				S_AXI_RRESP <= 2'h0;
				case (ar)
					{4'h0, `AX_CTRL}: S_AXI_RDATA <= {30'h0, 1'b0, reply_en_q};
					{4'h0, `AX_STAT}: S_AXI_RDATA <= {16'h0, last_op_q, status_q};
					{4'h0, `AX_IRQ_ST}: S_AXI_RDATA <= {29'h0, irq_st_q};
					`AX_IRQ_EN: S_AXI_RDATA <= {29'h0, irq_en_q};
					default: begin
						S_AXI_RDATA <= 32'h0;
						S_AXI_RRESP <= 2'h2;
					end
				endcase
			end else if (S_AXI_RVALID && S_AXI_RREADY) begin
				S_AXI_RVALID <= 1'b0;
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			TX_VALID <= 1'b0;
			TX_DATA <= 8'h00;
			SETTINGS <= '0;
		end else begin
			// Byte stands until the host takes it
			if (tx_take) begin
				TX_VALID <= tx_byte.valid;
				TX_DATA <= tx_byte.data;
			end
			SETTINGS <= set_q;
		end
	end
endmodule // cfg_decoder

// ---- hw/cfg_defines.svh ----
// Constants for the factory configuration command decoder
`ifndef CFG_DEFINES_SVH
`define CFG_DEFINES_SVH
`define FRM_HEADER 8'hcc
`define FRM_TRAILER 8'hdd
`define KEY_B0 8'hff
`define KEY_B1 8'hee
`define KEY_B2 8'hbb
`define KEY_B3 8'haa
`define REQ_LEN 4'hd
`define RSP_LEN 3'h7
`define ADDR_BCAST 8'hff
`define OP_NODE 8'h00
`define OP_R232 8'h01
`define OP_R485 8'h02
`define OP_CAN 8'h03
`define OP_SUBDIV 8'h05
`define OP_SPEED 8'h07
`define OP_HOME 8'h0e
`define OP_CANDST 8'h10
`define OP_GRP0 8'h50
`define OP_GRP3 8'h53
`define NODE_MAX 8'h7f
`define UART_MAX 8'h04
`define CAN_MAX 8'h03
`define SUB_MIN 8'h01
`define SUB_MAX 8'h05
`define SPD_MIN 16'h0001
`define SPD_MAX 16'h0258
`define GRP_MIN 8'h80
`define GRP_MAX 8'hfe
`define DEF_NODE 8'h00
`define DEF_UART 3'h0
`define DEF_CAN 2'h0
`define DEF_SUB 3'h3
`define DEF_SPD 16'h012c
`define DEF_HOME 1'b0
`define DEF_CANDST 8'h00
`define DEF_GRP 8'h00
`define ST_OK 8'h00
`define ST_FRAME 8'h01
`define ST_PARAM 8'h02
`define ST_REJECT 8'h07
`define AX_CTRL 4'h0
`define AX_STAT 4'h4
`define AX_IRQ_ST 4'h8
`define AX_IRQ_CLR 4'hc
`define AX_IRQ_EN 8'h10
`endif

// ---- hw/cfg_pkg.sv ----
// Types for the factory configuration command decoder
package cfg_pkg;
	typedef struct packed {
		logic [7:0] node;
		logic [2:0] rs232;
		logic [2:0] rs485;
		logic [1:0] can;
		logic [2:0] subdiv;
		logic [15:0] speed;
		logic home;
		logic [7:0] can_dst;
		logic [31:0] group;
	} settings_s;
	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} byte_s;
	typedef enum logic [1:0] {
		RX_IDLE,
		RX_BODY,
		RX_EXEC
	} rx_state_e;
endpackage

// ---- hw/reply_tx.sv ----
// Reply frame serialiser with running checksum
`timescale 1ns/1ns
`include "cfg_defines.svh"
module reply_tx (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic start,
	input wire logic [7:0] addr,
	input wire logic [7:0] status,
	input wire logic [15:0] sparam,
	input wire logic ready,
	output cfg_pkg::byte_s out,
	output logic busy
);
	logic [2:0] idx_q;
	logic [15:0] sum_q;
	logic [7:0] cur;
	logic [7:0] addr_q;
	logic [7:0] stat_q;
	logic [15:0] par_q;
	always_comb begin
		case (idx_q)
			3'h0: cur = `FRM_HEADER;
			3'h1: cur = addr_q;
			3'h2: cur = stat_q;
			3'h3: cur = par_q[7:0];
			3'h4: cur = par_q[15:8];
			3'h5: cur = `FRM_TRAILER;
			3'h6: cur = sum_q[7:0];
			default: cur = sum_q[15:8];
		endcase
	end
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			busy <= 1'b0;
			idx_q <= 3'h0;
			sum_q <= 16'h0000;
			addr_q <= 8'h00;
			stat_q <= 8'h00;
			par_q <= 16'h0000;
		end else if (start && !busy) begin
			busy <= 1'b1;
			idx_q <= 3'h0;
			sum_q <= 16'h0000;
			addr_q <= addr;
			stat_q <= status;
			par_q <= sparam;
		end else if (busy && ready) begin
			// Sum covers header through trailer
			if (idx_q <= 3'h5)
				sum_q <= sum_q + {8'h00, cur};
			idx_q <= idx_q + 3'h1;
			if (idx_q == `RSP_LEN)
				busy <= 1'b0;
		end
	end
	assign out.valid = busy;
	assign out.data = cur;
endmodule // reply_tx

// ---- verif/cfg_decoder_chk.sv ----
// Port checker for the configuration command decoder
`timescale 1ns/1ns
module cfg_decoder_chk (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic TX_VALID,
	input wire logic [7:0] TX_DATA,
	input wire logic TX_READY,
	input wire cfg_pkg::settings_s SETTINGS,
	input wire logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	function automatic bit grp_ok(input logic [31:0] g);
		for (int i = 0; i < 4; i++)
			if (g[i*8 +: 8] != 8'h00 && !(g[i*8 +: 8] inside {[8'h80:8'hfe]}))
				return 1'b0;
		return 1'b1;
	endfunction
	sequence tx_stall;
		TX_VALID && !TX_READY;
	endsequence
	sequence live;
		$past(RST_N) && $past(RST_N, 2);
	endsequence
	reply_hold_a: assert property (tx_stall |=> TX_VALID && $stable(TX_DATA))
		else $error("reply byte lost while stalled");
	bresp_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
		else $error("write response dropped");
	rresp_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID)
		else $error("read response dropped");
	node_range_a: assert property (SETTINGS.node <= 8'h7f)
		else $error("node address out of range");
	rate_range_a: assert property (SETTINGS.rs232 <= 3'h4 && SETTINGS.rs485 <= 3'h4)
		else $error("serial rate code out of range");
	subdiv_range_a: assert property (live |-> SETTINGS.subdiv inside {[3'h1:3'h5]})
		else $error("subdivision code out of range");
	speed_range_a: assert property (live |-> SETTINGS.speed inside {[16'h0001:16'h0258]})
		else $error("maximum speed out of range");
	group_range_a: assert property (grp_ok(SETTINGS.group))
		else $error("group address out of range");
endmodule // cfg_decoder_chk
bind cfg_decoder cfg_decoder_chk CHK (.*);

// ---- verif/factory_config_command_decoder_tb.sv ----
// Self-checking bench for the configuration command decoder
`timescale 1ns/1ns
module factory_config_command_decoder_tb;
	logic CLK, RST_N, RX_VALID, RX_READY, TX_VALID, TX_READY, IRQ;
	logic [7:0] RX_DATA, TX_DATA;
	cfg_pkg::settings_s SETTINGS;
	logic [31:0] S_AXI_AWADDR = '0, S_AXI_WDATA = '0, S_AXI_ARADDR = '0;
	logic [31:0] S_AXI_RDATA, rd;
	logic [3:0] S_AXI_WSTRB = 4'hf;
	logic S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b0;
	logic S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0;
	logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY;
	logic S_AXI_RVALID;
	logic [1:0] S_AXI_BRESP, S_AXI_RRESP, rs;
	int err_count = 0;
	int tests_run = 0;
	typedef struct {logic [7:0] op; logic [31:0] p; logic [15:0] f;
		logic [7:0] st;} row_s;
	row_s rows [18] = '{
		'{8'h00, 32'h7f, 16'h7f, 8'h00}, '{8'h00, 32'h80, 16'h7f, 8'h02},
		'{8'h01, 32'h4, 16'h4, 8'h00}, '{8'h01, 32'h5, 16'h4, 8'h02},
		'{8'h01, 32'h1, 16'h1, 8'h00}, '{8'h02, 32'h3, 16'h3, 8'h00},
		'{8'h03, 32'h3, 16'h3, 8'h00}, '{8'h05, 32'h5, 16'h5, 8'h00},
		'{8'h05, 32'h0, 16'h5, 8'h02}, '{8'h07, 32'h258, 16'h258, 8'h00},
		'{8'h07, 32'h259, 16'h258, 8'h02}, '{8'h0e, 32'h1, 16'h1, 8'h00},
		'{8'h10, 32'hff, 16'hff, 8'h00}, '{8'h50, 32'h81, 16'h81, 8'h00},
		'{8'h51, 32'h82, 16'h82, 8'h00}, '{8'h52, 32'h83, 16'h83, 8'h00},
		'{8'h53, 32'hfe, 16'hfe, 8'h00}, '{8'h53, 32'h7f, 16'hfe, 8'h02}};
	cfg_decoder DUT (.*);
	host_model HOST (.CLK(CLK), .RX_VALID(RX_VALID), .RX_DATA(RX_DATA),
		.RX_READY(RX_READY), .TX_VALID(TX_VALID), .TX_DATA(TX_DATA),
		.TX_READY(TX_READY));
	initial begin
		CLK = 1'b0;
		forever #4 CLK = ~CLK;
	end
	task automatic wrap_up;
		if (err_count == 0 && tests_run > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] g, e);
		tests_run++;
		if (g !== e) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk_rsp(input logic [7:0] st);
		logic [15:0] s;
		s = '0;
		for (int i = 0; i < 6; i++) s += 16'(HOST.rsp[i]);
		chk("rsp_len", 32'(HOST.n), 32'h8);
		chk("rsp_head", 32'(HOST.rsp[0]), 32'hcc);
		chk("rsp_stat", 32'(HOST.rsp[2]), 32'(st));
		chk("rsp_tail", 32'(HOST.rsp[5]), 32'hdd);
		chk("rsp_sum", 32'({HOST.rsp[7], HOST.rsp[6]}), 32'(s));
	endtask
	task automatic ax(input bit wr, input logic [31:0] a, d);
		bit b;
		b = 1'b0;
		@(posedge CLK);
		if (wr) begin
			S_AXI_AWADDR <= a;
			S_AXI_WDATA <= d;
			S_AXI_AWVALID <= 1'b1;
			S_AXI_WVALID <= 1'b1;
			S_AXI_BREADY <= 1'b1;
		end else begin
			S_AXI_ARADDR <= a;
			S_AXI_ARVALID <= 1'b1;
			S_AXI_RREADY <= 1'b1;
		end
		while (!b) begin
			@(posedge CLK);
			if (S_AXI_AWVALID && S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
			if (S_AXI_WVALID && S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
			if (S_AXI_ARVALID && S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
			if (S_AXI_BVALID && S_AXI_BREADY) begin
				b = 1'b1;
				S_AXI_BREADY <= 1'b0;
				rs = S_AXI_BRESP;
			end
			if (S_AXI_RVALID && S_AXI_RREADY) begin
				b = 1'b1;
				S_AXI_RREADY <= 1'b0;
				rs = S_AXI_RRESP;
				rd = S_AXI_RDATA;
			end
		end
	endtask
	function automatic logic [15:0] fld(input logic [7:0] op);
		case (op)
			8'h00: return 16'(SETTINGS.node);
			8'h01: return 16'(SETTINGS.rs232);
			8'h02: return 16'(SETTINGS.rs485);
			8'h03: return 16'(SETTINGS.can);
			8'h05: return 16'(SETTINGS.subdiv);
			8'h07: return SETTINGS.speed;
			8'h0e: return 16'(SETTINGS.home);
			8'h10: return 16'(SETTINGS.can_dst);
			default: return 16'(SETTINGS.group[op[1:0]*8 +: 8]);
		endcase
	endfunction
	initial begin
		repeat (20000) @(posedge CLK);
		err_count++;
		wrap_up;
	end
	initial begin
		RST_N = 1'b0;
		repeat (8) @(posedge CLK);
		RST_N <= 1'b1;
		repeat (3) @(posedge CLK);
		chk("dflt", {13'h0, SETTINGS.subdiv, SETTINGS.speed}, 32'h3012c);
		chk("dflt_grp", SETTINGS.group, 32'h0);
		ax(1'b0, 32'h0, 32'h0);
		chk("ctrl", 32'(rd[0]), 32'h1);
		foreach (rows[i]) begin
			HOST.xfer(8'hff, rows[i].op, rows[i].p, 8'hff, 8'h00, i % 2 * 4);
			chk_rsp(rows[i].st);
			chk("field", 32'(fld(rows[i].op)), 32'(rows[i].f));
		end
		HOST.xfer(8'h7f, 8'h0e, 32'h0, 8'hff, 8'h00, 0);
		chk_rsp(8'h00);
		chk("home", 32'(SETTINGS.home), 32'h0);
		HOST.xfer(8'h82, 8'h02, 32'h4, 8'hff, 8'h00, 0);
		chk_rsp(8'h00);
		chk("grp_hit", 32'(SETTINGS.rs485), 32'h4);
		HOST.xfer(8'h05, 8'h02, 32'h0, 8'hff, 8'h00, 0);
		chk("quiet", 32'(HOST.n), 32'h0);
		chk("no_hit", 32'(SETTINGS.rs485), 32'h4);
		HOST.xfer(8'hff, 8'h20, 32'h0, 8'hff, 8'h00, 0);
		chk_rsp(8'h02);
		chk("unk_keep", 32'(SETTINGS.rs485), 32'h4);
		ax(1'b1, 32'h10, 32'h2);
		HOST.xfer(8'h7f, 8'h00, 32'h10, 8'h00, 8'h00, 0);
		chk_rsp(8'h07);
		chk("bad_key", 32'(SETTINGS.node), 32'h7f);
		chk("irq_on", 32'(IRQ), 32'h1);
		ax(1'b0, 32'h8, 32'h0);
		chk("irq_st", 32'(rd[1]), 32'h1);
		chk("irq_unk", 32'(rd[2]), 32'h1);
		ax(1'b1, 32'hc, 32'h2);
		ax(1'b1, 32'h10, 32'h0);
		chk("irq_off", 32'(IRQ), 32'h0);
		HOST.xfer(8'h7f, 8'h00, 32'h10, 8'hff, 8'h01, 0);
		chk_rsp(8'h01);
		chk("bad_sum", 32'(SETTINGS.node), 32'h7f);
		chk("irq_mask", 32'(IRQ), 32'h0);
		ax(1'b0, 32'h4, 32'h0);
		chk("stat", rd, 32'h1);
		ax(1'b0, 32'h20, 32'h0);
		chk("unmapped", 32'(rs), 32'h2);
		ax(1'b1, 32'h0, 32'h3);
		repeat (2) @(posedge CLK);
		chk("init", {SETTINGS.node, SETTINGS.speed}, 32'h012c);
		wrap_up;
	end
endmodule // factory_config_command_decoder_tb

// ---- verif/host_model.sv ----
// Host controller model: sends request frames and takes replies
`timescale 1ns/1ns
module host_model (
	input wire logic CLK,
	output logic RX_VALID,
	output logic [7:0] RX_DATA,
	input wire logic RX_READY,
	input wire logic TX_VALID,
	input wire logic [7:0] TX_DATA,
	output logic TX_READY
);
	logic [7:0] rsp [8];
	int n;
	initial begin
		RX_VALID = 1'b0;
		RX_DATA = 8'h5a;
		TX_READY = 1'b0;
	end
	task automatic xfer(input logic [7:0] a, op, input logic [31:0] p,
		input logic [7:0] k0, sadj, input int slow);
		logic [7:0] f [14];
		logic [15:0] s;
		f = '{8'hcc, a, op, k0, 8'hee, 8'hbb, 8'haa, p[7:0], p[15:8],
			p[23:16], p[31:24], 8'hdd, 8'h00, 8'h00};
		s = 16'(sadj);
		for (int i = 0; i < 12; i++) s += 16'(f[i]);
		f[12] = s[7:0];
		f[13] = s[15:8];
		@(posedge CLK);
		for (int i = 0; i < 14; i++) begin
			RX_VALID <= 1'b1;
			RX_DATA <= f[i];
			do @(posedge CLK); while (!RX_READY);
		end
		RX_VALID <= 1'b0;
		RX_DATA <= ~f[13];
		n = 0;
		repeat (slow) @(posedge CLK);
		TX_READY <= 1'b1;
		repeat (40) begin
			@(posedge CLK);
			if (TX_VALID && n < 8) begin
				rsp[n] = TX_DATA;
				n++;
			end
		end
		TX_READY <= 1'b0;
	endtask
endmodule // host_model
